// *** ivc_pkg.sv ***
// Constants and carrier types for the interrupt vector controller.
// Assumes a single system clock domain and plain control/status ports.
package ivc_pkg;
    localparam int NUM_SRC = 35;
    localparam int NUM_TRAP = 4;
    localparam int VEC_W = 7;
    localparam int LVL_W = 4;
    localparam int PRI_W = 3;
    localparam int ADDR_W = 24;
    localparam logic [ADDR_W-1:0] PRIMARY_BASE = 24'h000004;
    localparam logic [ADDR_W-1:0] ALT_BASE = 24'h000104;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;
    localparam int TABLE_ENTRIES = 126;
    localparam int TRAP_VECTORS = 8;
    localparam int USER_VECTORS = 118;
    localparam logic [LVL_W-1:0] TRAP_LEVEL = 4'h8;
    localparam logic [VEC_W-1:0] NO_VECTOR = 7'h00;
    localparam int LEVEL_TOP_BIT = 3;
    localparam int FETCH_CYCLES = 2;

    // Vector number per user source, natural order (lowest vector first).
    localparam logic [NUM_SRC*VEC_W-1:0] SRC_VECTORS = {
        7'h7C, 7'h7B, 7'h7A, 7'h79, 7'h78, 7'h77, 7'h76,
        7'h71, 7'h70, 7'h6F,
        7'h69, 7'h68, 7'h67, 7'h66,
        7'h49, 7'h41, 7'h25,
        7'h1C, 7'h1B, 7'h1A, 7'h19, 7'h18,
        7'h15, 7'h14, 7'h13, 7'h12, 7'h11,
        7'h10, 7'h0F, 7'h0E, 7'h0D, 7'h0B, 7'h0A, 7'h09, 7'h08
    };
    // Trap vector numbers, natural order.
    localparam logic [NUM_TRAP*VEC_W-1:0] TRAP_VECTORS_MAP = {
        7'h04, 7'h03, 7'h02, 7'h01
    };

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_SERVE = 2'b11
    } ivc_state_t;

    typedef struct packed {
        logic [VEC_W-1:0] vector_number_field;
        logic [LVL_W-1:0] new_level_field;
        logic [ADDR_W-1:0] entry_address;
    } ivc_select_t;

    typedef struct packed {
        ivc_state_t state;
        logic [NUM_SRC-1:0] flags;
        ivc_select_t sel;
        logic [1:0] wait_count;
        logic core_request;
        logic fetch_strobe;
    } ivc_regs_t;
endpackage : ivc_pkg

// *** interrupt_vector_controller.sv ***
// Interrupt vector controller: merges sources and traps into one core request.
// Assumes the core acknowledges a request and returns with a one-cycle pulse.
`timescale 1ns/10ps
module interrupt_vector_controller (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ivc_pkg::NUM_SRC-1:0] source_event,
    input wire logic [ivc_pkg::NUM_SRC-1:0] flag_clear,
    input wire logic [ivc_pkg::NUM_SRC-1:0] source_enable,
    input wire logic [ivc_pkg::NUM_SRC*ivc_pkg::PRI_W-1:0] source_priority,
    input wire logic [ivc_pkg::NUM_TRAP-1:0] trap_event,
    input wire logic [ivc_pkg::LVL_W-1:0] cpu_priority_level,
    input wire logic alt_table_select,
    input wire logic core_ack,
    input wire logic core_return,
    output logic [ivc_pkg::NUM_SRC-1:0] source_flags,
    output logic core_request,
    output logic vector_fetch,
    output logic [ivc_pkg::VEC_W-1:0] vector_number_field,
    output logic [ivc_pkg::LVL_W-1:0] new_level_field,
    output logic [ivc_pkg::ADDR_W-1:0] vector_entry_address,
    output logic in_service
);
    ivc_pkg::ivc_regs_t r;
    ivc_pkg::ivc_regs_t next_r;
    logic [ivc_pkg::NUM_SRC-1:0] eligible;
    logic cand_valid;
    logic [ivc_pkg::VEC_W-1:0] cand_vec;
    logic [ivc_pkg::LVL_W-1:0] cand_lvl;
    logic [ivc_pkg::LVL_W-1:0] best_lvl;
    logic [ivc_pkg::ADDR_W-1:0] cand_addr;

    genvar g;
    generate
        for (g = 0; g < ivc_pkg::NUM_SRC; g++)
        begin : g_elig
            assign eligible[g] = r.flags[g] && source_enable[g]
                && !cpu_priority_level[ivc_pkg::LEVEL_TOP_BIT]
                && ({1'b0, source_priority[g*ivc_pkg::PRI_W +: ivc_pkg::PRI_W]}
                    > cpu_priority_level);
        end
    endgenerate

    always_comb
    begin
        cand_valid = 1'b0;
        cand_vec = ivc_pkg::NO_VECTOR;
        cand_lvl = '0;
        best_lvl = '0;
        for (int i = ivc_pkg::NUM_TRAP - 1; i >= 0; i--)
        begin
            if (trap_event[i])
            begin
                cand_valid = 1'b1;
                cand_vec = ivc_pkg::TRAP_VECTORS_MAP[i*ivc_pkg::VEC_W +: ivc_pkg::VEC_W];
                cand_lvl = ivc_pkg::TRAP_LEVEL;
            end
        end
        if (!cand_valid)
        begin
            for (int i = ivc_pkg::NUM_SRC - 1; i >= 0; i--)
            begin
                if (eligible[i]
                    && {1'b0, source_priority[i*ivc_pkg::PRI_W +: ivc_pkg::PRI_W]} >= best_lvl)
                begin
                    cand_valid = 1'b1;
                    best_lvl = {1'b0, source_priority[i*ivc_pkg::PRI_W +: ivc_pkg::PRI_W]};
                    cand_vec = ivc_pkg::SRC_VECTORS[i*ivc_pkg::VEC_W +: ivc_pkg::VEC_W];
                end
            end
            cand_lvl = best_lvl;
        end
    end

    always_comb
    begin
        cand_addr = (alt_table_select ? ivc_pkg::ALT_BASE : ivc_pkg::PRIMARY_BASE)
            + {16'h0000, cand_vec, 1'b0};
    end

    always_comb
    begin
        next_r = r;
        next_r.fetch_strobe = 1'b0;
        next_r.flags = (r.flags & ~flag_clear) | source_event;
        case (r.state)
            ivc_pkg::ST_IDLE:
            begin
                next_r.core_request = cand_valid;
                if (cand_valid && core_ack)
                begin
                    next_r.sel.vector_number_field = cand_vec;
                    next_r.sel.new_level_field = cand_lvl;
                    next_r.sel.entry_address = cand_addr;
                    next_r.core_request = 1'b0;
                    next_r.wait_count = 2'(ivc_pkg::FETCH_CYCLES - 1);
                    next_r.state = ivc_pkg::ST_FETCH;
                end
            end
            ivc_pkg::ST_FETCH:
            begin
                if (r.wait_count == 2'h0)
                begin
                    next_r.fetch_strobe = 1'b1;
                    next_r.state = ivc_pkg::ST_SERVE;
                end
                else
                begin
                    next_r.wait_count = r.wait_count - 2'h1;
                end
            end
            ivc_pkg::ST_SERVE:
            begin
                if (core_return)
                begin
                    next_r.state = ivc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_r.state = ivc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r <= '{state: ivc_pkg::ST_IDLE, flags: '0,
                   sel: '{ivc_pkg::NO_VECTOR, '0, ivc_pkg::RESET_ADDR},
                   wait_count: '0, core_request: 1'b0, fetch_strobe: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign source_flags = r.flags;
    assign core_request = r.core_request;
    assign vector_fetch = r.fetch_strobe;
    assign vector_number_field = r.sel.vector_number_field;
    assign new_level_field = r.sel.new_level_field;
    assign vector_entry_address = r.sel.entry_address;
    assign in_service = (r.state != ivc_pkg::ST_IDLE);

    // The properties below watch the outputs, the handshake and the internal r.state and eligible signals.
    // set wins clear
    a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
        source_event[0] |=> source_flags[0])
        else $error("flag lost on set");
    a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        flag_clear[0] && !source_event[0] |=> !source_flags[0])
        else $error("flag not cleared");
    a_top_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        cpu_priority_level[ivc_pkg::LEVEL_TOP_BIT] && trap_event == '0 && !in_service
        |=> !core_request)
        else $error("user request passed blocked level");

    // An accept is an idle edge at which the core acknowledges a raised request.
    sequence s_accept;
        !in_service && core_request && core_ack;
    endsequence
    // With no trap pending at the accept, a user source won the arbitration.
    sequence s_user_accept;
        s_accept and (trap_event == '0);
    endsequence
    // With a trap pending, the lowest-numbered pending trap wins the arbitration at the accept.
    sequence s_trap_accept;
        s_accept and (trap_event != '0);
    endsequence
    // The fetch strobe follows two quiet edges after the accept.
    sequence s_fetch_gap;
        ##2 !vector_fetch ##1 vector_fetch;
    endsequence

    a_fixed_latency: assert property (@(posedge clk_sys) disable iff (rst)
        s_accept |-> s_fetch_gap)
        else $error("entry latency varied");
    a_fetch_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        vector_fetch |=> !vector_fetch)
        else $error("fetch strobe longer than one cycle");
    a_return_idle: assert property (@(posedge clk_sys) disable iff (rst)
        (r.state == ivc_pkg::ST_SERVE) && core_return |=> !in_service)
        else $error("return did not end service");
    a_no_req_busy: assert property (@(posedge clk_sys) disable iff (rst)
        in_service |-> !core_request)
        else $error("request raised during service");
    a_single_req: assert property (@(posedge clk_sys) disable iff (rst)
        !in_service && trap_event[0] && !core_ack |=> core_request)
        else $error("trap did not raise request");

    a_primary_addr: assert property (@(posedge clk_sys) disable iff (rst)
        (s_accept and !alt_table_select)
        |=> vector_entry_address
            == ivc_pkg::PRIMARY_BASE + {16'h0000, vector_number_field, 1'b0})
        else $error("primary entry address wrong");
    a_alt_address: assert property (@(posedge clk_sys) disable iff (rst)
        (s_accept and alt_table_select)
        |=> vector_entry_address
            == ivc_pkg::ALT_BASE + {16'h0000, vector_number_field, 1'b0})
        else $error("alternate entry address wrong");
    a_entry_hold: assert property (@(posedge clk_sys) disable iff (rst)
        vector_fetch |-> $stable(vector_entry_address))
        else $error("entry address moved at fetch");

    a_level_latch: assert property (@(posedge clk_sys) disable iff (rst)
        s_trap_accept |=> new_level_field == ivc_pkg::TRAP_LEVEL)
        else $error("trap level not latched");
    a_trap_first: assert property (@(posedge clk_sys) disable iff (rst)
        s_trap_accept |=> vector_number_field < 7'(ivc_pkg::TRAP_VECTORS))
        else $error("trap not chosen first");
    a_trap_range: assert property (@(posedge clk_sys) disable iff (rst)
        s_trap_accept |=> vector_number_field != ivc_pkg::NO_VECTOR
            && vector_number_field <= 7'(ivc_pkg::NUM_TRAP))
        else $error("trap vector out of range");

    a_user_vector: assert property (@(posedge clk_sys) disable iff (rst)
        s_user_accept |=> vector_number_field >= 7'(ivc_pkg::TRAP_VECTORS))
        else $error("user vector in trap range");
    a_top_vector: assert property (@(posedge clk_sys) disable iff (rst)
        s_user_accept |=> vector_number_field < 7'(ivc_pkg::TABLE_ENTRIES - 1))
        else $error("user vector on reserved entry");
    a_first_source: assert property (@(posedge clk_sys) disable iff (rst)
        (s_user_accept and ($onehot(eligible) && eligible[0]))
        |=> vector_number_field == 7'(ivc_pkg::TRAP_VECTORS))
        else $error("first source vector wrong");
    a_level_range: assert property (@(posedge clk_sys) disable iff (rst)
        s_user_accept |=> new_level_field != '0 && !new_level_field[ivc_pkg::LEVEL_TOP_BIT])
        else $error("user level out of range");
    a_level_above: assert property (@(posedge clk_sys) disable iff (rst)
        s_user_accept |=> new_level_field > $past(cpu_priority_level))
        else $error("user level not above cpu level");

    generate
        for (g = 0; g < ivc_pkg::NUM_SRC; g++)
        begin : g_flag_chk
            a_flag_kept: assert property (@(posedge clk_sys) disable iff (rst)
                source_flags[g] && !flag_clear[g] |=> source_flags[g])
                else $error("flag dropped without clear");
            a_flag_raised: assert property (@(posedge clk_sys) disable iff (rst)
                !source_flags[g] && !source_event[g] |=> !source_flags[g])
                else $error("flag set without event");
        end
    endgenerate
endmodule : interrupt_vector_controller

// *** core_model.sv ***
// Behavioural model of the core that accepts requests and returns from service.
// Assumes the controller's single-cycle fetch pulse and level request.
`timescale 1ns/10ps
module core_model #(
    parameter int RET_DELAY = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic core_request,
    input wire logic vector_fetch,
    input wire logic in_service,
    output logic core_ack,
    output logic core_return
);
    int cnt;
    logic req;
    logic busy;
    logic fetch;
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_ack = 1'b0;
            core_return = 1'b0;
            cnt = 0;
        end
        else
        begin
            req = core_request;
            busy = in_service;
            fetch = vector_fetch;
            #1;
            core_ack = req && !busy && !core_ack;
            core_return = 1'b0;
            if (fetch)
                cnt = RET_DELAY;
            else if (cnt != 0)
            begin
                cnt--;
                core_return = (cnt == 0);
            end
        end
    end
endmodule : core_model

// *** interrupt_vector_controller_tb_top.sv ***
// Self-checking bench for the interrupt vector controller.
// Assumes core_model answers requests and the design's registered outputs.
`timescale 1ns/10ps
module interrupt_vector_controller_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [34:0] source_event = '0;
    logic [34:0] flag_clear = '0;
    logic [34:0] source_enable = '1;
    logic [104:0] source_priority = '0;
    logic [3:0] trap_event = '0;
    logic [3:0] cpu_priority_level = '0;
    logic alt_table_select = 1'b0;
    logic core_ack, core_return, core_request, vector_fetch, in_service;
    logic [34:0] source_flags;
    logic [6:0] vector_number_field;
    logic [3:0] new_level_field;
    logic [23:0] vector_entry_address;
    int miscompares = 0;
    int samples_checked = 0;
    int lat = 0;
    logic [6:0] vtab [35] = '{7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11,
        7'h12, 7'h13, 7'h14, 7'h15, 7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h25, 7'h41, 7'h49,
        7'h66, 7'h67, 7'h68, 7'h69, 7'h6F, 7'h70, 7'h71, 7'h76, 7'h77, 7'h78, 7'h79, 7'h7A,
        7'h7B, 7'h7C};
    interrupt_vector_controller DUT (.clk_sys(clk_sys), .rst(rst), .source_event(source_event),
        .flag_clear(flag_clear), .source_enable(source_enable),
        .source_priority(source_priority), .trap_event(trap_event),
        .cpu_priority_level(cpu_priority_level), .alt_table_select(alt_table_select),
        .core_ack(core_ack), .core_return(core_return), .source_flags(source_flags),
        .core_request(core_request), .vector_fetch(vector_fetch),
        .vector_number_field(vector_number_field), .new_level_field(new_level_field),
        .vector_entry_address(vector_entry_address), .in_service(in_service));
    core_model core (.clk_sys(clk_sys), .rst(rst), .core_request(core_request),
        .vector_fetch(vector_fetch), .in_service(in_service), .core_ack(core_ack),
        .core_return(core_return));
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic pulse(input logic [34:0] ev);
        source_event = ev;
        tick(1);
        source_event = '0;
    endtask : pulse
    task automatic idle_check();
        tick(6);
        check(core_request, 1'b0);
        check(in_service, 1'b0);
    endtask : idle_check
    // Raises sources or traps, waits for the fetch and checks the latched fields.
    task automatic serve(input logic [34:0] ev, input logic [3:0] tr, input logic [3:0] cpu,
        input logic [6:0] vec, input logic [3:0] lvl);
        int n;
        logic [23:0] addr;
        addr = (alt_table_select ? 24'h000104 : 24'h000004) + {16'h0000, vec, 1'b0};
        cpu_priority_level = cpu;
        trap_event = tr;
        pulse(ev);
        n = 0;
        while (vector_fetch !== 1'b1 && n < 50)
        begin
            tick(1);
            n++;
        end
        check(vector_number_field, vec);
        check(new_level_field, lvl);
        check(vector_entry_address, addr);
        check(source_flags & ev, ev);
        trap_event = '0;
        flag_clear = '1;
        tick(1);
        flag_clear = '0;
        tick(8);
        check(in_service, 1'b0);
        check(source_flags, 35'h0);
    endtask : serve
    always @(posedge clk_sys)
    begin
        if (vector_fetch === 1'b1)
            check(32'(lat), 32'h3);
        lat <= (core_ack && !in_service) ? 1 : lat + 1;
    end
    initial
    begin
        #100000;
        miscompares++;
        summarize();
    end
    initial
    begin
        for (int i = 0; i < 35; i++)
            source_priority[3*i +: 3] = 3'(i % 7 + 1);
        tick(16);
        rst = 1'b0;
        check(vector_entry_address, 24'h000000);
        for (int i = 0; i < 35; i++)
            serve(35'h1 << i, 4'h0, 4'h0, vtab[i], 4'(i % 7 + 1));
        alt_table_select = 1'b1;
        serve(35'h1, 4'h0, 4'h0, 7'h08, 4'h1);
        alt_table_select = 1'b0;
        cpu_priority_level = 4'h8;
        pulse(35'h1 << 10);
        pulse(35'h1 << 3);
        idle_check();
        serve(35'h0, 4'h0, 4'h0, 7'h0B, 4'h4);
        cpu_priority_level = 4'h8;
        pulse(35'h1 | (35'h1 << 34));
        serve(35'h0, 4'h0, 4'h0, 7'h7C, 4'h7);
        source_enable[1] = 1'b0;
        cpu_priority_level = 4'h0;
        pulse(35'h2);
        idle_check();
        source_enable = '1;
        cpu_priority_level = 4'h2;
        idle_check();
        serve(35'h0, 4'h0, 4'h1, 7'h09, 4'h2);
        serve(35'h1 << 34, 4'h1, 4'h0, 7'h01, 4'h8);
        serve(35'h0, 4'h8, 4'h8, 7'h04, 4'h8);
        pulse(35'h1);
        rst = 1'b1;
        tick(2);
        check(source_flags, 35'h0);
        check(vector_entry_address, 24'h000000);
        summarize();
    end
endmodule : interrupt_vector_controller_tb_top
